// ==== design/csrm_pkg.sv ====
// constants for the clock status readback and monitor select register bank
// assumes a 50 MHz system clock and 32-bit APB with word-aligned registers
package csrm_pkg;

	// register indexes; byte address is four times the index
	localparam logic [9:0] IDX_CTL  = 10'h1bb;
	localparam logic [9:0] IDX_RB0  = 10'h22c;
	localparam logic [9:0] IDX_RB1  = 10'h22d;
	localparam logic [9:0] IDX_MON  = 10'h230;
	localparam logic [9:0] IDX_IRQS = 10'h238;
	localparam logic [9:0] IDX_IRQM = 10'h239;
	localparam int         ADDR_W   = 12;
	localparam int         IDX_LSB  = 2;

	// control register fields
	localparam int CTL_PD   = 7;
	localparam int CTL_CH1  = 1;
	localparam int CTL_CH0  = 0;
	localparam logic [2:0] CTL_RST = 3'h0;

	// monitor select
	localparam int         MON_W   = 6;
	localparam logic [5:0] MON_RST = 6'h00;

	// readback 1 fields
	localparam int RB1_HOLD = 3;
	localparam int RB1_REFERENCE_B = 2;
	localparam int RB1_CAL  = 0;

	// interrupt events
	localparam int IRQ_W        = 5;
	localparam int EV_IN_UNLK   = 0;
	localparam int EV_OUT_UNLK  = 1;
	localparam int EV_HOLD      = 2;
	localparam int EV_REF_SWAP  = 3;
	localparam int EV_CAL_DONE  = 4;
	localparam logic [4:0] IRQ_RST = 5'h00;

	// synchronised status inputs, bit positions
	localparam int ST_W      = 15;
	localparam int S_REFERENCE_A    = 0;
	localparam int S_REFERENCE_B    = 1;
	localparam int S_TEST    = 2;
	localparam int S_VCXO    = 3;
	localparam int S_FB      = 4;
	localparam int S_OREF    = 5;
	localparam int S_IN_LK   = 6;
	localparam int S_OUT_LK  = 7;
	localparam int S_HOLD    = 8;
	localparam int S_AUTO_B  = 9;
	localparam int S_CAL     = 10;
	localparam int S_FB_CLK  = 11;
	localparam int S_PFD_DN  = 12;
	localparam int S_REF_CLK = 13;
	localparam int S_PFD_UP  = 14;

	localparam logic [ST_W-1:0] ST_RST = 15'h0000;

endpackage : csrm_pkg

// ==== design/csrm_sync.sv ====
// two-flop synchroniser for a vector of independent status levels
// assumes each bit is a slow level or a clock well below half of clk
`timescale 1ns/1ns
module csrm_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         sys_rst,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);

	logic [W-1:0] meta;

	// first stage feeds only the second
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			meta     <= '0;
			sync_out <= '0;
		end else begin
			meta     <= async_in;
			sync_out <= meta;
		end
	end

endmodule : csrm_sync

// ==== design/csrm_top.sv ====
// APB register bank: loop output control, clock presence and lock
// readback, status monitor pin select and an event interrupt.
// assumes status inputs arrive from analog or other clock domains.
//
// Function
// - control bit 7 set powers down the buffered input-loop output driver.
// - control bit 1 routes the VCXO (1) or VCO divider (0) to channel 1.
// - control bit 0 routes the VCXO (1) or VCO divider (0) to channel 0.
// - readback 0 bits 7..2 show presence of out ref, fb, VCXO, test, B, A.
// - readback 0 bits 1 and 0 show output and input loop lock.
// - readback 1 bit 3 shows the holdover status input.
// - readback 1 bit 2 shows the auto-selected reference, 1 for B.
// - readback 1 bit 0 shows VCO calibration running.
// - monitor codes 0..3 give low, both locked, input lock, output lock.
// - codes 4..6 give both refs missing, that and out lock, ref B chosen.
// - codes 7..12 give presence of A, B, test, VCXO, fb, out ref.
// - code 13 reserved, 14 both refs present, 15 all but test present.
// - codes 16..19 give fb, pfd down, ref, pfd up each halved.
`timescale 1ns/1ns
module csrm_top (
	input  wire logic        clk,
	input  wire logic        sys_rst,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// status from the clock core, asynchronous
	input  wire logic        reference_a_ok,
	input  wire logic        reference_b_ok,
	input  wire logic        test_ref_ok,
	input  wire logic        vcxo_ok,
	input  wire logic        feedback_ok,
	input  wire logic        out_ref_ok,
	input  wire logic        input_cleanup_loop_lock,
	input  wire logic        output_synthesis_loop_lock,
	input  wire logic        holdover,
	input  wire logic        auto_sel_reference_b,
	input  wire logic        vco_cal_busy,
	input  wire logic        feedback_clk,
	input  wire logic        pfd_down,
	input  wire logic        reference_clk,
	input  wire logic        pfd_up,
	// controls to the clock core
	output logic             loop_out_power_down,
	output logic             ch1_src_vcxo,
	output logic             ch0_src_vcxo,
	output logic             status_monitor,
	output logic             irq
);

	typedef struct packed {
		logic [2:0]                    ctl;
		logic [csrm_pkg::MON_W-1:0]    mon_sel;
		logic [csrm_pkg::IRQ_W-1:0]    irq_stat;
		logic [csrm_pkg::IRQ_W-1:0]    irq_mask;
		logic [31:0]                   rdata;
		logic                          err;
		logic [3:0]                    half;
		logic [3:0]                    edge_prev;
		logic [csrm_pkg::ST_W-1:0]     st_prev;
		logic                          mon;
	} csrm_state_t;

	csrm_state_t cur;
	csrm_state_t next_cur;

	logic [csrm_pkg::ST_W-1:0] st_async;
	logic [csrm_pkg::ST_W-1:0] st;

	assign st_async = {
		pfd_up,
		reference_clk,
		pfd_down,
		feedback_clk,
		vco_cal_busy,
		auto_sel_reference_b,
		holdover,
		output_synthesis_loop_lock,
		input_cleanup_loop_lock,
		out_ref_ok,
		feedback_ok,
		vcxo_ok,
		test_ref_ok,
		reference_b_ok,
		reference_a_ok
	};

	csrm_sync #(
		.W (csrm_pkg::ST_W)
	) u_sync (
		.clk      (clk),
		.sys_rst  (sys_rst),
		.async_in (st_async),
		.sync_out (st)
	);

	// word address match against a register index
	function automatic logic hit(
		input logic [11:0] addr,
		input logic [9:0]  idx
	);
		hit = (addr[11:csrm_pkg::IDX_LSB] == idx);
	endfunction : hit

	// readback 0 packed from live synchronised state
	function automatic logic [7:0] rb0(
		input logic [csrm_pkg::ST_W-1:0] s
	);
		rb0 = {
			s[csrm_pkg::S_OREF],
			s[csrm_pkg::S_FB],
			s[csrm_pkg::S_VCXO],
			s[csrm_pkg::S_TEST],
			s[csrm_pkg::S_REFERENCE_B],
			s[csrm_pkg::S_REFERENCE_A],
			s[csrm_pkg::S_OUT_LK],
			s[csrm_pkg::S_IN_LK]
		};
	endfunction : rb0

	logic [7:0] rb0_val;
	logic [7:0] rb1_val;
	logic       refs_gone;
	logic       mapped;
	logic       setup_ph;
	logic       acc_wr;
	logic       acc_rd;
	logic [3:0] div_in;
	logic [csrm_pkg::IRQ_W-1:0] events;
	logic [csrm_pkg::IRQ_W-1:0] clr;

	always_comb begin
		rb0_val = rb0(st);
		rb1_val = 8'h00;
		rb1_val[csrm_pkg::RB1_HOLD] = st[csrm_pkg::S_HOLD];
		rb1_val[csrm_pkg::RB1_REFERENCE_B] = st[csrm_pkg::S_AUTO_B];
		rb1_val[csrm_pkg::RB1_CAL]  = st[csrm_pkg::S_CAL];
		refs_gone = ~st[csrm_pkg::S_REFERENCE_A] & ~st[csrm_pkg::S_REFERENCE_B];
		div_in = {
			st[csrm_pkg::S_PFD_UP],
			st[csrm_pkg::S_REF_CLK],
			st[csrm_pkg::S_PFD_DN],
			st[csrm_pkg::S_FB_CLK]
		};
	end

	always_comb begin
		mapped = hit(paddr, csrm_pkg::IDX_CTL)
			| hit(paddr, csrm_pkg::IDX_RB0)
			| hit(paddr, csrm_pkg::IDX_RB1)
			| hit(paddr, csrm_pkg::IDX_MON)
			| hit(paddr, csrm_pkg::IDX_IRQS)
			| hit(paddr, csrm_pkg::IDX_IRQM);
		setup_ph = psel & ~penable;
		acc_wr   = psel & penable & pwrite & mapped & pstrb[0];
		acc_rd   = psel & penable & ~pwrite;
	end

	// events come from edges of synchronised state
	always_comb begin
		events = '0;
		events[csrm_pkg::EV_IN_UNLK] =
			cur.st_prev[csrm_pkg::S_IN_LK] & ~st[csrm_pkg::S_IN_LK];
		events[csrm_pkg::EV_OUT_UNLK] =
			cur.st_prev[csrm_pkg::S_OUT_LK] & ~st[csrm_pkg::S_OUT_LK];
		events[csrm_pkg::EV_HOLD] =
			~cur.st_prev[csrm_pkg::S_HOLD] & st[csrm_pkg::S_HOLD];
		events[csrm_pkg::EV_REF_SWAP] =
			cur.st_prev[csrm_pkg::S_AUTO_B] ^ st[csrm_pkg::S_AUTO_B];
		events[csrm_pkg::EV_CAL_DONE] =
			cur.st_prev[csrm_pkg::S_CAL] & ~st[csrm_pkg::S_CAL];
	end

	// read clears only what the read returned, so a new event survives
	always_comb begin
		clr = '0;
		if (acc_rd && hit(paddr, csrm_pkg::IDX_IRQS)) begin
			clr = cur.rdata[csrm_pkg::IRQ_W-1:0];
		end
	end

	always_comb begin
		next_cur = cur;
		next_cur.st_prev   = st;
		next_cur.edge_prev = div_in;
		next_cur.irq_stat  = (cur.irq_stat & ~clr) | events;

		// halved copies toggle on each rising edge
		for (int i = 0; i < 4; i++) begin
			if (div_in[i] && !cur.edge_prev[i]) begin
				next_cur.half[i] = ~cur.half[i];
			end
		end

		// writes take effect at the access edge; readbacks ignore writes
		if (acc_wr) begin
			if (hit(paddr, csrm_pkg::IDX_CTL)) begin
				next_cur.ctl = {
					pwdata[csrm_pkg::CTL_PD],
					pwdata[csrm_pkg::CTL_CH1],
					pwdata[csrm_pkg::CTL_CH0]
				};
			end
			if (hit(paddr, csrm_pkg::IDX_MON)) begin
				next_cur.mon_sel = pwdata[csrm_pkg::MON_W-1:0];
			end
			if (hit(paddr, csrm_pkg::IDX_IRQM)) begin
				next_cur.irq_mask = pwdata[csrm_pkg::IRQ_W-1:0];
			end
		end

		// read data captured in setup so it is stable in access
		if (setup_ph) begin
			next_cur.rdata = 32'h0000_0000;
			next_cur.err   = ~mapped;
			if (!pwrite) begin
				if (hit(paddr, csrm_pkg::IDX_CTL)) begin
					next_cur.rdata[csrm_pkg::CTL_PD]  = cur.ctl[2];
					next_cur.rdata[csrm_pkg::CTL_CH1] = cur.ctl[1];
					next_cur.rdata[csrm_pkg::CTL_CH0] = cur.ctl[0];
				end
				if (hit(paddr, csrm_pkg::IDX_RB0)) begin
					next_cur.rdata[7:0] = rb0_val;
				end
				if (hit(paddr, csrm_pkg::IDX_RB1)) begin
					next_cur.rdata[7:0] = rb1_val;
				end
				if (hit(paddr, csrm_pkg::IDX_MON)) begin
					next_cur.rdata[csrm_pkg::MON_W-1:0] = cur.mon_sel;
				end
				if (hit(paddr, csrm_pkg::IDX_IRQS)) begin
					next_cur.rdata[csrm_pkg::IRQ_W-1:0] = cur.irq_stat;
				end
				if (hit(paddr, csrm_pkg::IDX_IRQM)) begin
					next_cur.rdata[csrm_pkg::IRQ_W-1:0] = cur.irq_mask;
				end
			end
		end

		// monitor pin mux; codes past 23 are not to be written
		case (cur.mon_sel)
			6'h00: next_cur.mon = 1'b0;
			6'h01: next_cur.mon = st[csrm_pkg::S_IN_LK]
				& st[csrm_pkg::S_OUT_LK];
			6'h02: next_cur.mon = st[csrm_pkg::S_IN_LK];
			6'h03: next_cur.mon = st[csrm_pkg::S_OUT_LK];
			6'h04: next_cur.mon = refs_gone;
			6'h05: next_cur.mon = refs_gone
				& st[csrm_pkg::S_OUT_LK];
			6'h06: next_cur.mon = st[csrm_pkg::S_AUTO_B];
			6'h07: next_cur.mon = st[csrm_pkg::S_REFERENCE_A];
			6'h08: next_cur.mon = st[csrm_pkg::S_REFERENCE_B];
			6'h09: next_cur.mon = st[csrm_pkg::S_TEST];
			6'h0a: next_cur.mon = st[csrm_pkg::S_VCXO];
			6'h0b: next_cur.mon = st[csrm_pkg::S_FB];
			6'h0c: next_cur.mon = st[csrm_pkg::S_OREF];
			6'h0e: next_cur.mon = st[csrm_pkg::S_REFERENCE_A]
				& st[csrm_pkg::S_REFERENCE_B];
			6'h0f: next_cur.mon = st[csrm_pkg::S_REFERENCE_A]
				& st[csrm_pkg::S_REFERENCE_B]
				& st[csrm_pkg::S_VCXO]
				& st[csrm_pkg::S_FB]
				& st[csrm_pkg::S_OREF];
			6'h10: next_cur.mon = cur.half[0];
			6'h11: next_cur.mon = cur.half[1];
			6'h12: next_cur.mon = cur.half[2];
			6'h13: next_cur.mon = cur.half[3];
			// reserved code 13 and 20 upward drive low
			default: next_cur.mon = 1'b0;
		endcase

		if (sys_rst) begin
			next_cur           = '0;
			next_cur.ctl       = csrm_pkg::CTL_RST;
			next_cur.mon_sel   = csrm_pkg::MON_RST;
			next_cur.irq_stat  = csrm_pkg::IRQ_RST;
			next_cur.irq_mask  = csrm_pkg::IRQ_RST;
			next_cur.st_prev   = csrm_pkg::ST_RST;
		end
	end

	always_ff @(posedge clk) begin
		cur <= next_cur;
	end

	assign pready              = 1'b1;
	assign prdata              = cur.rdata;
	assign pslverr             = cur.err & psel & penable;
	assign loop_out_power_down = cur.ctl[2];
	assign ch1_src_vcxo        = cur.ctl[1];
	assign ch0_src_vcxo        = cur.ctl[0];
	assign status_monitor      = cur.mon;
	assign irq                 = |(cur.irq_stat & cur.irq_mask);

endmodule : csrm_top

// ==== tb/csrm_top_properties.sv ====
// assertions on the ports of the clock status register bank
// assumes zero-wait APB and status levels held steady before reads
`timescale 1ns/1ns
module csrm_props (
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	input  wire logic [31:0] prdata,
	input  wire logic        output_synthesis_loop_lock,
	input  wire logic        holdover,
	input  wire logic        loop_out_power_down,
	input  wire logic        ch1_src_vcxo,
	input  wire logic        ch0_src_vcxo,
	input  wire logic        status_monitor
);
	wire logic acc = psel && penable;
	wire logic wr  = acc && pwrite && pstrb[0];
	wire logic rd  = acc && !pwrite;
	wire logic wm  = wr && paddr == 12'h8c0;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	power_down_a: assert property (
		wr && paddr == 12'h6ec |=> loop_out_power_down == $past(pwdata[7]))
		else $error("power down bit not taken");
	ch1_route_a: assert property (
		wr && paddr == 12'h6ec |=> ch1_src_vcxo == $past(pwdata[1]))
		else $error("channel 1 route not taken");
	ch0_route_a: assert property (
		wr && paddr == 12'h6ec |=> ch0_src_vcxo == $past(pwdata[0]))
		else $error("channel 0 route not taken");
	ctl_readback_a: assert property (
		rd && paddr == 12'h6ec |-> prdata[7:0] == {loop_out_power_down,
		5'h00, ch1_src_vcxo, ch0_src_vcxo})
		else $error("control readback differs");
	upper_zero_a: assert property (rd |-> prdata[31:8] == 24'h0)
		else $error("upper read bits set");
	rb1_reserved_a: assert property (
		rd && paddr == 12'h8b4 |-> prdata[7:4] == 4'h0 && !prdata[1])
		else $error("reserved readback bits set");
	out_lock_read_a: assert property (
		output_synthesis_loop_lock [*6] ##0 (rd && paddr == 12'h8b0)
		|-> prdata[1]) else $error("lock flag not read");
	holdover_read_a: assert property (
		holdover [*6] ##0 (rd && paddr == 12'h8b4) |-> prdata[3])
		else $error("holdover flag not read");
	mon_ground_a: assert property (
		wm && pwdata[5:0] == 6'h00 |-> ##2 !status_monitor)
		else $error("monitor code 0 not low");
	mon_reserved_a: assert property (
		wm && pwdata[5:0] == 6'h0d |-> ##2 !status_monitor)
		else $error("monitor code 13 not low");
	mon_upper_a: assert property (
		wm && pwdata[5:2] == 4'h5 |-> ##2 !status_monitor)
		else $error("monitor codes 20 to 23 not low");
	cover property (rd && paddr == 12'h8b0);
	cover property (wm && pwdata[5:0] == 6'h10);
	cover property (wr && paddr == 12'h6ec && pwdata[7]);
endmodule : csrm_props
bind csrm_top csrm_props chk_u (.clk, .sys_rst, .psel, .penable, .pwrite,
	.paddr, .pwdata, .pstrb, .prdata, .output_synthesis_loop_lock, .holdover,
	.loop_out_power_down, .ch1_src_vcxo, .ch0_src_vcxo, .status_monitor);

// ==== tb/tb.sv ====
// self-checking bench for the status register bank, random status levels
// assumes zero-wait APB and two-flop synchronised status inputs
`timescale 1ns/1ns
module tb;
	logic        clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0;
	logic        pwrite = 1'b0, pready, pslverr, pd, c1, c0, mon, irq, m0, err;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0, prdata, rd, r;
	logic [3:0]  pstrb = 4'h0;
	logic [14:0] st = 15'h0;
	integer      mismatches = 0, n_compared = 0, seed = 92401, ctl = 0, i, j;
	always #10 clk = ~clk;
	csrm_top dut_u (.clk, .sys_rst, .psel, .penable, .pwrite, .paddr,
		.pwdata, .pstrb, .prdata, .pready, .pslverr,
		.reference_a_ok(st[0]), .reference_b_ok(st[1]), .test_ref_ok(st[2]),
		.vcxo_ok(st[3]), .feedback_ok(st[4]), .out_ref_ok(st[5]),
		.input_cleanup_loop_lock(st[6]), .output_synthesis_loop_lock(st[7]),
		.holdover(st[8]), .auto_sel_reference_b(st[9]), .vco_cal_busy(st[10]),
		.feedback_clk(st[11]), .pfd_down(st[12]), .reference_clk(st[13]),
		.pfd_up(st[14]), .loop_out_power_down(pd), .ch1_src_vcxo(c1),
		.ch0_src_vcxo(c0), .status_monitor(mon), .irq);
	task automatic summarize;
		if (mismatches == 0 && n_compared > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : summarize
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// master waits for pready; only the watchdog ends a stuck wait
	task automatic apb(input logic w, input logic [11:0] a,
			input logic [31:0] d, input logic [3:0] s);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	function automatic logic mexp(input integer c, input logic [14:0] s);
		case (c)
			1: return s[6] & s[7];
			2: return s[6];
			3: return s[7];
			4: return !s[0] & !s[1];
			5: return !s[0] & !s[1] & s[7];
			6: return s[9];
			7, 8, 9, 10, 11, 12: return s[c-7];
			14: return s[0] & s[1];
			15: return s[0] & s[1] & s[3] & s[4] & s[5];
			default: return 1'b0;
		endcase
	endfunction : mexp
	initial begin
		#200000;
		mismatches++;
		summarize();
	end
	initial begin
		repeat (6) @(posedge clk);
		sys_rst <= 1'b0;
		for (i = 0; i < 8; i++) begin
			r = $random(seed);
			apb(1'b1, 12'h6ec, r, r[11:8]);
			if (r[8]) ctl = r & 32'h83;
			@(posedge clk);
			chk(32'({pd, c1, c0}), {ctl[7], ctl[1], ctl[0]});
			apb(1'b0, 12'h6ec, 32'h0, 4'h0);
			chk(rd, ctl);
		end
		apb(1'b0, 12'h004, 32'h0, 4'h0);
		chk(rd, 32'h0);
		chk(32'({err, pready}), 32'h3);
		// halving sources kept quiet here, their toggles are checked later
		for (i = 0; i < 12; i++) begin
			st <= 15'($random(seed)) & 15'h07ff;
			repeat (4) @(posedge clk);
			apb(1'b1, 12'h8b0, 32'hffffffff, 4'hf);
			apb(1'b0, 12'h8b0, 32'h0, 4'h0);
			chk(rd, 32'({st[5:0], st[7], st[6]}));
			apb(1'b0, 12'h8b4, 32'h0, 4'h0);
			chk(rd, 32'({st[8], st[9], 1'b0, st[10]}));
		end
		for (i = 0; i < 24; i++) begin
			apb(1'b1, 12'h8c0, 32'(i), 4'h1);
			for (j = 0; j < 3; j++) begin
				st <= 15'($random(seed)) & 15'h07ff;
				repeat (4) @(posedge clk);
				chk(32'(mon), 32'(mexp(i, st)));
			end
		end
		for (i = 16; i < 20; i++) begin
			apb(1'b1, 12'h8c0, 32'(i), 4'h1);
			repeat (4) @(posedge clk);
			m0 = mon;
			st[i-5] <= 1'b1;
			repeat (4) @(posedge clk);
			st[i-5] <= 1'b0;
			repeat (4) @(posedge clk);
			chk(32'(mon), 32'(!m0));
		end
		// interrupt: clear stale events, then lose input lock masked and not
		for (j = 1; j >= 0; j--) begin
			st <= 15'h0040;
			repeat (4) @(posedge clk);
			apb(1'b0, 12'h8e0, 32'h0, 4'h0);
			apb(1'b1, 12'h8e4, 32'(j), 4'h1);
			st <= 15'h0000;
			repeat (5) @(posedge clk);
			chk(32'(irq), 32'(j));
			apb(1'b0, 12'h8e0, 32'h0, 4'h0);
			chk(rd, 32'h1);
			@(posedge clk);
			chk(32'(irq), 32'h0);
		end
		summarize();
	end
endmodule : tb
